// *** design/pmc_pkg.sv ***
package pmc_pkg;

  // Bus geometry.
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  localparam int IDX_W  = ADDR_W - 2;

  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_LINK_STATUS_TWO  = 10'h072;
  localparam logic [IDX_W-1:0] IDX_SLOT_CAP_TWO     = 10'h074;
  localparam logic [IDX_W-1:0] IDX_SLOT_CTL_TWO     = 10'h078;
  localparam logic [IDX_W-1:0] IDX_SLOT_STS_TWO     = 10'h07a;
  localparam logic [IDX_W-1:0] IDX_POWER_MGMT_CAP   = 10'h0c0;
  localparam logic [IDX_W-1:0] IDX_FIELD_LOCK       = 10'h100;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Link status two layout.
  localparam int LS2_DEEMPH_BIT = 0;
  localparam logic DEEMPH_6DB  = 1'h0;
  localparam logic DEEMPH_3DB5 = 1'h1;

  // Power management capability layout.
  localparam int PM_CAP_IDENTIFIER_LSB  = 0;
  localparam int PM_NEXT_LSB   = 8;
  localparam int PM_REV_LSB    = 16;
  localparam int PM_WCLK_BIT   = 19;
  localparam int PM_DEV_SPECIFIC_INIT_BIT  = 21;
  localparam int PM_AUX_LSB    = 22;
  localparam int PM_LIGHT_BIT  = 25;
  localparam int PM_DEEP_BIT   = 26;
  localparam int PM_WAKE_LSB   = 27;
  localparam int PM_NEXT_BYTE  = 1;
  localparam int PM_DEV_SPECIFIC_INIT_BYTE = 2;
  localparam int PM_WAKE_BYTE  = 3;
  localparam int PM_WAKE_W     = 5;

  localparam logic [7:0] PM_CAP_IDENTIFIER_VAL     = 8'h01;
  localparam logic [2:0] PM_REV_VAL       = 3'h3;
  localparam logic       PM_WCLK_VAL      = 1'h0;
  localparam logic       PM_DEV_SPECIFIC_INIT_RST     = 1'h0;
  localparam logic [2:0] PM_AUX_VAL       = 3'h0;
  localparam logic       PM_LIGHT_VAL     = 1'h0;
  localparam logic       PM_DEEP_VAL      = 1'h0;
  localparam logic [4:0] PM_WAKE_RST      = 5'h19;
  localparam logic [7:0] PM_NEXT_RST      = 8'hd0;

  // Wake state index within the support field; the top one is powered off.
  localparam int WAKE_IDX_COLD = 4;
  localparam logic [2:0] WAKE_IDX_COLD_V = 3'h4;

  // Field lock register layout.
  localparam int LOCK_BIT = 0;

  typedef enum logic [2:0] {
    PMC_SEL_NONE,
    PMC_SEL_LSTS2,
    PMC_SEL_SCAP2,
    PMC_SEL_SCTL2,
    PMC_SEL_SSTS2,
    PMC_SEL_POWER_MGMT_CAPABILITIES,
    PMC_SEL_LOCK
  } pmc_sel_t;

endpackage : pmc_pkg

// *** design/pmc_wake_gate.sv ***
`timescale 1ns/100ps
module pmc_wake_gate
  import pmc_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  resetn,
  input  wire logic [PM_WAKE_W-1:0]  gen_mask,
  input  wire logic [1:0]            power_state,
  input  wire logic                  powered_off,
  input  wire logic                  wake_event,
  output logic                       wake_forward
);
  import pmc_pkg::*;

  logic [2:0] state_idx;
  logic       allowed;
  logic       wake_forward_q;
  logic       wake_forward_d;

  assign state_idx      = powered_off ? WAKE_IDX_COLD_V : {1'b0, power_state};
  // Nothing is forwarded while the port is powered off, whatever the mask says.
  assign allowed        = gen_mask[state_idx] & ~powered_off;
  assign wake_forward_d = wake_event & allowed;
  assign wake_forward   = wake_forward_q;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      wake_forward_q <= 1'b0;
    end else begin
      wake_forward_q <= wake_forward_d;
    end
  end

endmodule : pmc_wake_gate

// *** design/pmc_regs.sv ***
// Operation
// - Bit 0 of link status two shows de-emphasis at 5.0 Gbps: 0 is -6 dB.
// - At 2.5 GT/s the de-emphasis bit carries no meaning.
// - Slot capability, control, status two and link status bits 15:1 read zero.
// - Power management capability bits 7:0 read 0x1.
// - Bits 15:8 hold a lockable pointer to the next capability.
// - Read-only revision field, bits 18:16, reads 0x3.
// - Bit 19, wake clock needed, reads zero.
// - Lockable bit 21, device specific init, resets to zero.
// - Auxiliary current field, bits 24:22, reads zero.
// - Bits 25 and 26 read zero: no intermediate sleep states.
// - Lockable wake support field, bits 31:27, resets to 0b11001.
// - Wake messages are never forwarded while powered off.
// - Writing wake support changes only the readback, not wake behaviour.
`timescale 1ns/100ps
module pmc_regs
  import pmc_pkg::*;
(
  input  wire logic [0:0]          clock,
  input  wire logic                resetn,
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]          s_axi_awprot,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [DATA_W-1:0]   s_axi_wdata,
  input  wire logic [STRB_W-1:0]   s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]          s_axi_arprot,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                link_speed_5g,
  input  wire logic                deemph_level_in,
  input  wire logic [1:0]          power_state,
  input  wire logic                powered_off,
  input  wire logic                wake_event,
  output logic                     wake_forward
);
  import pmc_pkg::*;

  // Maps a byte address onto a register; unaligned or unknown gives none.
  function automatic pmc_sel_t pmc_decode(input logic [ADDR_W-1:0] addr);
    pmc_sel_t sel;
    sel = PMC_SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      case (addr[ADDR_W-1:2])
        IDX_LINK_STATUS_TWO: sel = PMC_SEL_LSTS2;
        IDX_SLOT_CAP_TWO:    sel = PMC_SEL_SCAP2;
        IDX_SLOT_CTL_TWO:    sel = PMC_SEL_SCTL2;
        IDX_SLOT_STS_TWO:    sel = PMC_SEL_SSTS2;
        IDX_POWER_MGMT_CAP:  sel = PMC_SEL_POWER_MGMT_CAPABILITIES;
        IDX_FIELD_LOCK:      sel = PMC_SEL_LOCK;
        default:             sel = PMC_SEL_NONE;
      endcase
    end
    return sel;
  endfunction : pmc_decode

  // Answers an access: an unknown or unaligned address gets a slave error.
  function automatic logic [1:0] pmc_resp(input pmc_sel_t sel);
    logic [1:0] resp;
    resp = (sel == PMC_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    return resp;
  endfunction : pmc_resp

  // Bus handshake state.
  logic                  awready_q;
  logic                  awready_d;
  logic                  wready_q;
  logic                  wready_d;
  logic                  bvalid_q;
  logic                  bvalid_d;
  logic [1:0]            bresp_q;
  logic [1:0]            bresp_d;
  logic                  arready_q;
  logic                  arready_d;
  logic                  rvalid_q;
  logic                  rvalid_d;
  logic [1:0]            rresp_q;
  logic [1:0]            rresp_d;
  logic [DATA_W-1:0]     rdata_q;
  logic [DATA_W-1:0]     rdata_d;
  logic [ADDR_W-1:0]     awaddr_q;
  logic [ADDR_W-1:0]     awaddr_d;
  logic [DATA_W-1:0]     wdata_q;
  logic [DATA_W-1:0]     wdata_d;
  logic [STRB_W-1:0]     wstrb_q;
  logic [STRB_W-1:0]     wstrb_d;
  logic                  aw_held_q;
  logic                  aw_held_d;
  logic                  w_held_q;
  logic                  w_held_d;

  // Register contents.
  logic                  deemph_q;
  logic                  deemph_d;
  logic [7:0]            next_cap_pointer_q;
  logic [7:0]            next_cap_pointer_d;
  logic                  dev_specific_init_q;
  logic                  dev_specific_init_d;
  logic [PM_WAKE_W-1:0]  wake_state_support_q;
  logic [PM_WAKE_W-1:0]  wake_state_support_d;
  logic                  field_lock_q;
  logic                  field_lock_d;

  // Decode and selection.
  wire logic             aw_take;
  wire logic             w_take;
  wire logic             ar_take;
  wire logic             wr_go;
  wire logic             b_done;
  wire logic             r_done;
  wire pmc_sel_t         wr_sel;
  wire pmc_sel_t         rd_sel;
  wire logic             wr_power_mgmt_capabilities;
  wire logic             wr_open;
  wire logic             wr_lock;
  wire logic [DATA_W-1:0] link_status_two_rd;
  wire logic [DATA_W-1:0] power_mgmt_cap_rd;
  wire logic [DATA_W-1:0] field_lock_rd;
  wire logic [DATA_W-1:0] read_word;
  wire logic [PM_WAKE_W-1:0] wake_gen_mask;

  // Protection bits are ignored; every access is treated alike.
  // A write is applied once both halves are held and no response is still pending.
  assign aw_take  = s_axi_awvalid & awready_q;
  assign w_take   = s_axi_wvalid & wready_q;
  assign ar_take  = s_axi_arvalid & arready_q;
  assign wr_go    = aw_held_q & w_held_q & ~bvalid_q;
  assign b_done   = bvalid_q & s_axi_bready;
  assign r_done   = rvalid_q & s_axi_rready;
  assign wr_sel   = pmc_decode(awaddr_q);
  assign rd_sel   = pmc_decode(s_axi_araddr);
  assign wr_power_mgmt_capabilities = wr_go & (wr_sel == PMC_SEL_POWER_MGMT_CAPABILITIES);
  assign wr_open  = wr_power_mgmt_capabilities & ~field_lock_q;
  assign wr_lock  = wr_go & (wr_sel == PMC_SEL_LOCK) & wstrb_q[0];

  // Only bit 0 of link status two is live; the rest read zero.
  assign link_status_two_rd = {{(DATA_W-1){1'b0}}, deemph_q};

  assign power_mgmt_cap_rd = {wake_state_support_q,
                              PM_DEEP_VAL,
                              PM_LIGHT_VAL,
                              PM_AUX_VAL,
                              dev_specific_init_q,
                              1'b0,
                              PM_WCLK_VAL,
                              PM_REV_VAL,
                              next_cap_pointer_q,
                              PM_CAP_IDENTIFIER_VAL};

  assign field_lock_rd = {{(DATA_W-1){1'b0}}, field_lock_q};

  // Slot registers and unmapped addresses read zero.
  assign read_word = (rd_sel == PMC_SEL_LSTS2) ? link_status_two_rd :
                     (rd_sel == PMC_SEL_POWER_MGMT_CAPABILITIES) ? power_mgmt_cap_rd :
                     (rd_sel == PMC_SEL_LOCK)  ? field_lock_rd :
                     {DATA_W{1'b0}};

  // Wake generation follows the reset mask, never the writable readback.
  assign wake_gen_mask = PM_WAKE_RST;

  // Write address and data are taken in either order; the response follows both.
  assign awready_d = aw_take ? 1'b0 : (b_done ? 1'b1 : awready_q);
  assign wready_d  = w_take ? 1'b0 : (b_done ? 1'b1 : wready_q);
  assign aw_held_d = aw_take ? 1'b1 : (wr_go ? 1'b0 : aw_held_q);
  assign w_held_d  = w_take ? 1'b1 : (wr_go ? 1'b0 : w_held_q);
  assign awaddr_d  = aw_take ? s_axi_awaddr : awaddr_q;
  assign wdata_d   = w_take ? s_axi_wdata : wdata_q;
  assign wstrb_d   = w_take ? s_axi_wstrb : wstrb_q;
  assign bvalid_d  = wr_go ? 1'b1 : (b_done ? 1'b0 : bvalid_q);
  assign bresp_d   = wr_go ? pmc_resp(wr_sel) : bresp_q;

  assign arready_d = ar_take ? 1'b0 : (r_done ? 1'b1 : arready_q);
  assign rvalid_d  = ar_take ? 1'b1 : (r_done ? 1'b0 : rvalid_q);
  assign rdata_d   = ar_take ? read_word : rdata_q;
  assign rresp_d   = ar_take ? pmc_resp(rd_sel) : rresp_q;

  // The live level is shown only at 5.0 Gbps; at 2.5 GT/s it reads a fixed zero.
  assign deemph_d = link_speed_5g ? deemph_level_in : DEEMPH_6DB;

  // Lockable fields take byte-enabled writes only while unlocked; other capability bits ignore writes, and the lock bit takes any write with byte 0 enabled.
  assign next_cap_pointer_d = (wr_open & wstrb_q[PM_NEXT_BYTE]) ?
                              wdata_q[PM_NEXT_LSB +: 8] : next_cap_pointer_q;
  assign dev_specific_init_d = (wr_open & wstrb_q[PM_DEV_SPECIFIC_INIT_BYTE]) ?
                               wdata_q[PM_DEV_SPECIFIC_INIT_BIT] : dev_specific_init_q;
  assign wake_state_support_d = (wr_open & wstrb_q[PM_WAKE_BYTE]) ?
                                wdata_q[PM_WAKE_LSB +: PM_WAKE_W] : wake_state_support_q;
  assign field_lock_d = wr_lock ? wdata_q[LOCK_BIT] : field_lock_q;

  // Every bus output comes straight from its register.
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Write address side: the slot stays closed from its take until the response is accepted.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      awready_q <= 1'b1;
      aw_held_q <= 1'b0;
      awaddr_q  <= '0;
    end else begin
      awready_q <= awready_d;
      aw_held_q <= aw_held_d;
      awaddr_q  <= awaddr_d;
    end
  end

  // Write data side: data and strobes wait here until the address has arrived too.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wready_q <= 1'b1;
      w_held_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else begin
      wready_q <= wready_d;
      w_held_q <= w_held_d;
      wdata_q  <= wdata_d;
      wstrb_q  <= wstrb_d;
    end
  end

  // Write response: raised when the write is applied, dropped when the master accepts it.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else begin
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
    end
  end

  // Read channel: the answer stands until the master accepts it.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else begin
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // The reported de-emphasis level follows the link one clock late.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      deemph_q <= DEEMPH_6DB;
    end else begin
      deemph_q <= deemph_d;
    end
  end

  // Lockable capability fields.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      next_cap_pointer_q   <= PM_NEXT_RST;
      dev_specific_init_q  <= PM_DEV_SPECIFIC_INIT_RST;
      wake_state_support_q <= PM_WAKE_RST;
    end else begin
      next_cap_pointer_q   <= next_cap_pointer_d;
      dev_specific_init_q  <= dev_specific_init_d;
      wake_state_support_q <= wake_state_support_d;
    end
  end

  // Lock that freezes the capability fields against writes.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      field_lock_q <= 1'b0;
    end else begin
      field_lock_q <= field_lock_d;
    end
  end

  // Wake messages are filtered against the fixed generation mask and the power state.
  pmc_wake_gate u_wake_gate (
    .clock        (clock),
    .resetn       (resetn),
    .gen_mask     (wake_gen_mask),
    .power_state  (power_state),
    .powered_off  (powered_off),
    .wake_event   (wake_event),
    .wake_forward (wake_forward)
  );

endmodule : pmc_regs

// *** tb/pmc_regs_monitor.sv ***
`timescale 1ns/100ps
module pmc_regs_checker
  import pmc_pkg::*;
(
  input wire logic [0:0]        clock,
  input wire logic              resetn,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic [1:0]        power_state,
  input wire logic              powered_off,
  input wire logic              wake_event,
  input wire logic              wake_forward
);
  import pmc_pkg::*;
  localparam logic [ADDR_W-1:0] A_LS2 = {IDX_LINK_STATUS_TWO, 2'h0};
  localparam logic [ADDR_W-1:0] A_PM  = {IDX_POWER_MGMT_CAP, 2'h0};
  logic [ADDR_W-1:0] rd_addr_q;
  logic              slot_hit;
  // The read address is remembered so the answer can be matched to its register.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rd_addr_q <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_addr_q <= s_axi_araddr;
    end
  end
  assign slot_hit = (rd_addr_q == {IDX_SLOT_CAP_TWO, 2'h0}) || (rd_addr_q == {IDX_SLOT_CTL_TWO, 2'h0})
                  || (rd_addr_q == {IDX_SLOT_STS_TWO, 2'h0});
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  a_wake_cold_blocked: assert property (wake_event && powered_off |=> !wake_forward)
    else $error("wake forwarded while powered off");
  a_wake_states_pass: assert property (
    wake_event && !powered_off && power_state inside {2'h0, 2'h3} |=> wake_forward)
    else $error("wake not forwarded in a supported state");
  a_wake_sleep_blocked: assert property (
    wake_event && power_state inside {2'h1, 2'h2} |=> !wake_forward)
    else $error("wake forwarded in a sleep state");
  a_wake_has_cause: assert property (wake_forward |-> $past(wake_event))
    else $error("wake forwarded without an event");
  a_slot_read_zero: assert property (
    s_axi_rvalid && slot_hit |-> s_axi_rdata == '0 && s_axi_rresp == RESP_OKAY)
    else $error("slot register read not zero");
  a_link_upper_zero: assert property (
    s_axi_rvalid && rd_addr_q == A_LS2 |-> s_axi_rdata[31:1] == '0)
    else $error("link status two upper bits not zero");
  a_pm_fixed_fields: assert property (
    s_axi_rvalid && rd_addr_q == A_PM |->
    s_axi_rdata[7:0] == 8'h01 && s_axi_rdata[20:16] == 5'h03 && s_axi_rdata[26:22] == 5'h00)
    else $error("power capability fixed fields wrong");
  a_read_next_cycle: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule : pmc_regs_checker

bind pmc_regs pmc_regs_checker u_chk (.clock(clock), .resetn(resetn), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .power_state(power_state),
  .powered_off(powered_off), .wake_event(wake_event), .wake_forward(wake_forward));

// *** tb/tb_pmc_regs.sv ***
`timescale 1ns/100ps
module tb_pmc_regs;
  import pmc_pkg::*;
  localparam logic [ADDR_W-1:0] A_LS2  = {IDX_LINK_STATUS_TWO, 2'h0};
  localparam logic [ADDR_W-1:0] A_PM   = {IDX_POWER_MGMT_CAP, 2'h0};
  localparam logic [ADDR_W-1:0] A_LOCK = {IDX_FIELD_LOCK, 2'h0};
  logic [0:0]        clock;
  logic              resetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, power_state;
  logic              link_speed_5g, deemph_level_in, powered_off, wake_event, wake_forward;
  logic [ADDR_W-1:0] ro_a [4];
  int                n_mismatch, check_count;

  pmc_regs DUT (.clock(clock), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .link_speed_5g(link_speed_5g), .deemph_level_in(deemph_level_in),
    .power_state(power_state), .powered_off(powered_off), .wake_event(wake_event), .wake_forward(wake_forward));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic close_out();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  // Address and data are offered together; each is dropped at the edge that takes it.
  task automatic wr_chk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    bit aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clock);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clock);
      if (awvalid && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk_word({what, " write resp"}, {30'h0, er}, {30'h0, bresp});
  endtask : wr_chk

  task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clock); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk_word(what, exp, rdata);
    chk_word({what, " read resp"}, {30'h0, er}, {30'h0, rresp});
  endtask : rd_chk

  // States 0 to 3 are powered, index 4 is the powered-off state; only D0 and D3hot forward.
  task automatic wake_sweep();
    for (int i = 0; i < 5; i++) begin
      @(posedge clock);
      power_state <= (i < 4) ? i[1:0] : 2'h3;
      powered_off <= (i == 4);
      wake_event <= 1'b1;
      @(posedge clock);
      wake_event <= 1'b0;
      @(posedge clock);
      chk_bit("wake_forward", (i == 0) || (i == 3), wake_forward);
    end
  endtask : wake_sweep

  initial begin
    resetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    power_state = 2'h0;
    powered_off = 1'b0;
    link_speed_5g = 1'b0;
    deemph_level_in = 1'b0;
    wake_event = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    ro_a = '{A_LS2, {IDX_SLOT_CAP_TWO, 2'h0}, {IDX_SLOT_CTL_TWO, 2'h0}, {IDX_SLOT_STS_TWO, 2'h0}};
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    rd_chk("pm caps reset", A_PM, 32'hc803d001, RESP_OKAY);
    rd_chk("field lock reset", A_LOCK, 32'h0, RESP_OKAY);
    wake_sweep();
    // At 2.5 GT/s the de-emphasis bit must read zero even with the level input high.
    deemph_level_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd_chk("status reset", ro_a[i], 32'h0, RESP_OKAY);
      wr_chk("status", ro_a[i], 32'hffffffff, 4'hf, RESP_OKAY);
      rd_chk("status after write", ro_a[i], 32'h0, RESP_OKAY);
    end
    wr_chk("pm caps", A_PM, 32'hffffffff, 4'hf, RESP_OKAY);
    rd_chk("pm caps all ones", A_PM, 32'hf823ff01, RESP_OKAY);
    wake_sweep();
    wr_chk("wake support", A_PM, 32'h0, 4'h8, RESP_OKAY);
    rd_chk("wake support cleared", A_PM, 32'h0023ff01, RESP_OKAY);
    wake_sweep();
    wr_chk("lock on", A_LOCK, 32'h1, 4'hf, RESP_OKAY);
    wr_chk("pm caps locked", A_PM, 32'h0, 4'hf, RESP_OKAY);
    rd_chk("pm caps locked", A_PM, 32'h0023ff01, RESP_OKAY);
    wr_chk("lock off", A_LOCK, 32'h0, 4'hf, RESP_OKAY);
    wr_chk("next pointer", A_PM, 32'h0000d000, 4'h2, RESP_OKAY);
    rd_chk("next pointer", A_PM, 32'h0023d001, RESP_OKAY);
    rd_chk("unmapped", 12'h004, 32'h0, RESP_SLVERR);
    wr_chk("unaligned", A_PM + 12'h2, 32'hffffffff, 4'hf, RESP_SLVERR);
    rd_chk("pm caps intact", A_PM, 32'h0023d001, RESP_OKAY);
    link_speed_5g <= 1'b1;
    deemph_level_in <= 1'b1;
    repeat (2) @(posedge clock);
    rd_chk("deemph minus 3.5", A_LS2, 32'h1, RESP_OKAY);
    deemph_level_in <= 1'b0;
    repeat (2) @(posedge clock);
    rd_chk("deemph minus 6", A_LS2, 32'h0, RESP_OKAY);
    wr_chk("lock before reset", A_LOCK, 32'h1, 4'hf, RESP_OKAY);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    rd_chk("field lock second reset", A_LOCK, 32'h0, RESP_OKAY);
    rd_chk("pm caps second reset", A_PM, 32'hc803d001, RESP_OKAY);
    close_out();
  end

  initial begin
    repeat (4000) @(posedge clock);
    n_mismatch++;
    close_out();
  end
endmodule : tb_pmc_regs
